/* verilog/power_mode_pkg.sv */
// Shared constants and types for the power-mode controller
package power_mode_pkg;
	// Power control register field positions
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int GP_LSB   = 2;
	localparam int GP_MSB   = 7;
	// Oscillator control register suspend bit position
	localparam int SUSPEND_BIT = 5;
	// Reset values
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] OSC_CONTROL_RESET   = 8'h00;
	// Restart address after any reset
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// Missing-clock timeout in microseconds and its cycle count
	localparam int CLK_MHZ             = 50;
	localparam int CLK_WATCH_US        = 100;
	localparam int CLK_WATCH_CYCLES    = CLK_WATCH_US * CLK_MHZ;
	localparam int CLK_WATCH_CNT_W     = 13;
	// Reset pulse length issued by this block, in cycles
	localparam int INT_RESET_CYCLES    = 4;
	localparam int RST_CNT_W           = 3;
	// Power modes
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_STOP,
		MODE_SUSPEND
	} power_mode_t;
endpackage : power_mode_pkg

/* verilog/wake_sync.sv */
// Two-stage synchroniser for wake pins from outside the clock domain
`timescale 1ns/1ps
module wake_sync (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       reset_n_in,
	// Asynchronous wake inputs
	input  wire logic [1:0] async_in,
	// Synchronised outputs
	output logic      [1:0] sync_out
);
	logic [1:0] stage1_reg;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			stage1_reg <= 2'h0;
			sync_out   <= 2'h0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule : wake_sync

/* verilog/power_mode_controller.sv */
// Power-mode controller: idle, stop and suspend entry and exit
`timescale 1ns/1ps
module power_mode_controller (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	// External reset pin, asynchronous
	input  wire logic        ext_reset_n_in,
	// Power control register write port from the CPU
	input  wire logic        power_wr_in,
	input  wire logic [7:0]  power_wdata_in,
	output logic      [7:0]  power_control_rdata_out,
	// Oscillator control register suspend bit write port
	input  wire logic        osc_wr_in,
	input  wire logic [7:0]  osc_wdata_in,
	output logic      [7:0]  osc_control_rdata_out,
	// CPU instruction boundary and interrupt status
	input  wire logic        instr_done_in,
	input  wire logic        irq_pending_in,
	// Watchdog and missing-clock detector controls
	input  wire logic        watchdog_expired_in,
	input  wire logic        clk_watch_en_in,
	// Wake pins, asynchronous
	input  wire logic        port_match_in,
	input  wire logic        comparator_low_in,
	// Clock and reset controls
	output logic             cpu_clk_en_out,
	output logic             periph_clk_en_out,
	output logic             int_osc_en_out,
	output logic             irq_timer_en_out,
	output logic             sys_reset_n_out,
	output logic      [15:0] reset_vector_out,
	output logic      [1:0]  power_mode_out,
	output logic             wake_irq_out
);
	power_mode_pkg::power_mode_t mode_reg;
	power_mode_pkg::power_mode_t mode_next;

	logic [7:0] gp_flags_reg;
	logic       idle_req_reg;
	logic       stop_req_reg;
	logic       suspend_req_reg;
	logic [7:0] osc_reg;
	logic [1:0] wake_sync;
	logic       ext_rst_s1_reg;
	logic       ext_rst_s2_reg;
	logic [power_mode_pkg::CLK_WATCH_CNT_W-1:0] clk_watch_cnt_reg;
	logic       clk_watch_fire;
	logic [power_mode_pkg::RST_CNT_W-1:0] rst_cnt_reg;
	logic       reset_cause;
	logic       wake_irq_reg;

	// Wake pins cross into the system clock domain
	wake_sync u_wake_sync (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({comparator_low_in, port_match_in}),
		.sync_out   (wake_sync)
	);

	// External reset pin synchroniser
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			ext_rst_s1_reg <= 1'b1;
			ext_rst_s2_reg <= 1'b1;
		end else begin
			ext_rst_s1_reg <= ext_reset_n_in;
			ext_rst_s2_reg <= ext_rst_s1_reg;
		end
	end

	// Missing-clock detector counts only in stop mode while clk_watch_en_in is set
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || mode_reg != power_mode_pkg::MODE_STOP ||
		    !clk_watch_en_in) begin
			clk_watch_cnt_reg <= '0;
		end else if (!clk_watch_fire) begin
			clk_watch_cnt_reg <= clk_watch_cnt_reg + 1'b1;
		end
	end
	assign clk_watch_fire = (clk_watch_cnt_reg ==
		power_mode_pkg::CLK_WATCH_CNT_W'(
			power_mode_pkg::CLK_WATCH_CYCLES - 1));

	// Watchdog has effect only outside stop, where its timer is frozen
	assign reset_cause = !ext_rst_s2_reg || clk_watch_fire ||
		(watchdog_expired_in &&
		 mode_reg != power_mode_pkg::MODE_STOP);

	// Internal reset pulse; stretched so the core sees it reliably
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			rst_cnt_reg <= '0;
		end else if (reset_cause) begin
			rst_cnt_reg <= power_mode_pkg::RST_CNT_W'(
				power_mode_pkg::INT_RESET_CYCLES);
		end else if (rst_cnt_reg != '0) begin
			rst_cnt_reg <= rst_cnt_reg - 1'b1;
		end
	end

	// Power control register: select bits are requests, not storage
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || rst_cnt_reg != '0) begin
			gp_flags_reg <= power_mode_pkg::POWER_CONTROL_RESET;
			idle_req_reg <= 1'b0;
			stop_req_reg <= 1'b0;
		end else begin
			if (power_wr_in) begin
				gp_flags_reg[power_mode_pkg::GP_MSB:power_mode_pkg::GP_LSB]
					<= power_wdata_in[power_mode_pkg::GP_MSB:
					                 power_mode_pkg::GP_LSB];
			end
			// Request waits for the writing instruction to finish
			if (power_wr_in && power_wdata_in[power_mode_pkg::IDLE_BIT]) begin
				idle_req_reg <= 1'b1;
			end else if (mode_reg == power_mode_pkg::MODE_IDLE &&
			             irq_pending_in) begin
				idle_req_reg <= 1'b0;
			end else if (instr_done_in) begin
				idle_req_reg <= 1'b0;
			end
			if (power_wr_in && power_wdata_in[power_mode_pkg::STOP_BIT]) begin
				stop_req_reg <= 1'b1;
			end else if (instr_done_in) begin
				stop_req_reg <= 1'b0;
			end
		end
	end

	// Oscillator control register; suspend bit is never stored and always reads as zero
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || rst_cnt_reg != '0) begin
			osc_reg         <= power_mode_pkg::OSC_CONTROL_RESET;
			suspend_req_reg <= 1'b0;
		end else begin
			if (osc_wr_in) begin
				osc_reg <= osc_wdata_in;
				osc_reg[power_mode_pkg::SUSPEND_BIT] <= 1'b0;
			end
			if (osc_wr_in && osc_wdata_in[power_mode_pkg::SUSPEND_BIT]) begin
				suspend_req_reg <= 1'b1;
			end else if (instr_done_in) begin
				suspend_req_reg <= 1'b0;
			end
		end
	end

	// Mode selection
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			power_mode_pkg::MODE_RUN: begin
				if (instr_done_in && stop_req_reg) begin
					mode_next = power_mode_pkg::MODE_STOP;
				end else if (instr_done_in && suspend_req_reg) begin
					mode_next = power_mode_pkg::MODE_SUSPEND;
				end else if (instr_done_in && idle_req_reg) begin
					mode_next = power_mode_pkg::MODE_IDLE;
				end
			end
			power_mode_pkg::MODE_IDLE: begin
				if (irq_pending_in) begin
					mode_next = power_mode_pkg::MODE_RUN;
				end
			end
			power_mode_pkg::MODE_STOP: begin
				mode_next = power_mode_pkg::MODE_STOP;
			end
			power_mode_pkg::MODE_SUSPEND: begin
				if (|wake_sync) begin
					mode_next = power_mode_pkg::MODE_RUN;
				end
			end
			default: mode_next = power_mode_pkg::MODE_RUN;
		endcase
	end

	// Any reset returns the core to run
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || rst_cnt_reg != '0) begin
			mode_reg <= power_mode_pkg::MODE_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Wake interrupt when suspend ends on a wake pin
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			wake_irq_reg <= 1'b0;
		end else begin
			wake_irq_reg <= (mode_reg == power_mode_pkg::MODE_SUSPEND) &&
				(|wake_sync);
		end
	end

	// Clock gating: idle stops only the CPU clock, PC is left untouched
	assign cpu_clk_en_out    = (mode_reg == power_mode_pkg::MODE_RUN);
	assign periph_clk_en_out = (mode_reg == power_mode_pkg::MODE_RUN) ||
		(mode_reg == power_mode_pkg::MODE_IDLE);
	assign int_osc_en_out    = (mode_reg == power_mode_pkg::MODE_RUN) ||
		(mode_reg == power_mode_pkg::MODE_IDLE);
	assign irq_timer_en_out  = (mode_reg != power_mode_pkg::MODE_STOP);

	assign sys_reset_n_out   = (rst_cnt_reg == '0);
	assign reset_vector_out  = power_mode_pkg::RESET_VECTOR;
	assign power_mode_out    = mode_reg;
	assign wake_irq_out      = wake_irq_reg;

	// Select bits always read back as zero
	always_comb begin
		power_control_rdata_out = gp_flags_reg;
		power_control_rdata_out[power_mode_pkg::IDLE_BIT] = 1'b0;
		power_control_rdata_out[power_mode_pkg::STOP_BIT] = 1'b0;
		osc_control_rdata_out = osc_reg;
	end
endmodule : power_mode_controller

/* bench/power_mode_controller_assertions.sv */
// Checker of mode and clock-control outputs
`timescale 1ns/1ps
module power_mode_controller_assertions (
	input wire logic        sys_clk_in,
	input wire logic        reset_n_in,
	input wire logic        ext_reset_n_in,
	input wire logic        instr_done_in,
	input wire logic        irq_pending_in,
	input wire logic        clk_watch_en_in,
	input wire logic [7:0]  power_control_rdata_out,
	input wire logic        cpu_clk_en_out,
	input wire logic        periph_clk_en_out,
	input wire logic        int_osc_en_out,
	input wire logic        irq_timer_en_out,
	input wire logic        sys_reset_n_out,
	input wire logic [15:0] reset_vector_out,
	input wire logic [1:0]  power_mode_out,
	input wire logic        wake_irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	a_idle_clock_gate: assert property (power_mode_out == 2'h1 |->
		!cpu_clk_en_out && periph_clk_en_out && int_osc_en_out)
		else $error("idle clock gating wrong");
	a_stop_all_off: assert property (power_mode_out == 2'h2 |->
		!(cpu_clk_en_out | periph_clk_en_out | int_osc_en_out |
		irq_timer_en_out)) else $error("stop left something running");
	a_suspend_halted: assert property (power_mode_out == 2'h3 |->
		!cpu_clk_en_out && !int_osc_en_out) else $error("suspend not halted");
	a_select_bits_zero: assert property (
		power_control_rdata_out[1:0] == 2'h0) else $error("select bits read 1");
	a_irq_ends_idle: assert property (
		power_mode_out == 2'h1 && irq_pending_in |=> power_mode_out == 2'h0)
		else $error("interrupt did not end idle");
	a_stop_holds: assert property (power_mode_out == 2'h2 &&
		!clk_watch_en_in && ext_reset_n_in && $past(ext_reset_n_in) &&
		$past(ext_reset_n_in, 2) && $past(ext_reset_n_in, 3) |=>
		power_mode_out == 2'h2) else $error("stop left without reset");
	a_entry_on_done: assert property (power_mode_out != 2'h0 &&
		$past(power_mode_out) == 2'h0 |-> $past(instr_done_in))
		else $error("mode entered mid instruction");
	a_reset_restart: assert property ($fell(sys_reset_n_out) |->
		(!sys_reset_n_out[*4]) and (##1 (power_mode_out == 2'h0 &&
		reset_vector_out == 16'h0000))) else $error("bad reset sequence");
	a_wake_from_susp: assert property (wake_irq_out |->
		power_mode_out == 2'h0 && $past(power_mode_out) == 2'h3)
		else $error("wake pulse outside suspend exit");
endmodule : power_mode_controller_assertions

/* bench/cpu_model.sv */
// CPU stand-in that completes instructions only while its clock runs
`timescale 1ns/1ps
module cpu_model (
	// Clock
	input  wire logic sys_clk_in,
	// Gated enable and step request
	input  wire logic cpu_clk_en_in,
	input  wire logic step_in,
	// Completion pulse
	output logic      instr_done_out
);
	// A halted core finishes nothing; the step after a mode write stands
	// for a multi-byte instruction, so no wake is lost
	always_ff @(posedge sys_clk_in) begin
		instr_done_out <= step_in && cpu_clk_en_in;
	end
endmodule : cpu_model

/* bench/power_mode_controller_bench.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
module power_mode_controller_bench;
	logic        sys_clk_in, reset_n_in, ext_reset_n_in, power_wr_in;
	logic [7:0]  power_wdata_in, osc_wdata_in, power_control_rdata_out;
	logic [7:0]  osc_control_rdata_out;
	logic        osc_wr_in, instr_done_in, irq_pending_in, step;
	logic        watchdog_expired_in, clk_watch_en_in, port_match_in;
	logic        comparator_low_in, cpu_clk_en_out, periph_clk_en_out;
	logic        int_osc_en_out, irq_timer_en_out, sys_reset_n_out;
	logic        wake_irq_out;
	logic [15:0] reset_vector_out;
	logic [1:0]  power_mode_out;
	logic [31:0] seed;
	int          mismatches, total_checks, cycles, i;
	power_mode_controller DUT (.sys_clk_in, .reset_n_in, .ext_reset_n_in,
		.power_wr_in, .power_wdata_in, .power_control_rdata_out, .osc_wr_in,
		.osc_wdata_in, .osc_control_rdata_out, .instr_done_in,
		.irq_pending_in, .watchdog_expired_in, .clk_watch_en_in,
		.port_match_in, .comparator_low_in, .cpu_clk_en_out,
		.periph_clk_en_out, .int_osc_en_out, .irq_timer_en_out,
		.sys_reset_n_out, .reset_vector_out, .power_mode_out, .wake_irq_out);
	cpu_model CPU (.sys_clk_in, .cpu_clk_en_in(cpu_clk_en_out),
		.step_in(step), .instr_done_out(instr_done_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic enter(input logic osc, input logic [7:0] d);
		@(posedge sys_clk_in);
		power_wr_in <= !osc;
		osc_wr_in <= osc;
		power_wdata_in <= d;
		osc_wdata_in <= d;
		@(posedge sys_clk_in);
		{power_wr_in, osc_wr_in} <= 2'b00;
		step <= 1'b1;
		@(posedge sys_clk_in);
		step <= 1'b0;
	endtask : enter
	task automatic wait_mode(input logic [1:0] m);
		for (i = 0; i < 40 && power_mode_out !== m; i++) @(posedge sys_clk_in);
		#1 chk(16'(power_mode_out), 16'(m));
	endtask : wait_mode
	task automatic wait_rst(input int n);
		for (i = 0; i < n && sys_reset_n_out !== 1'b0; i++)
			@(posedge sys_clk_in);
		#1 chk({power_mode_out, sys_reset_n_out, reset_vector_out[12:0]},
			16'h0);
	endtask : wait_rst
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cycles++;
		// Whole run needs well under 8000 cycles
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		{reset_n_in, power_wr_in, osc_wr_in, step, irq_pending_in} = '0;
		{watchdog_expired_in, clk_watch_en_in, port_match_in} = '0;
		{comparator_low_in, power_wdata_in, osc_wdata_in} = '0;
		ext_reset_n_in = 1'b1;
		seed = 32'hcc1f5810;
		repeat (16) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			enter(1'b0, {seed[7:2], 2'b01});
			wait_mode(2'h1);
			chk(16'({cpu_clk_en_out, periph_clk_en_out}), 16'h1);
			chk(16'(power_control_rdata_out), 16'({seed[7:2], 2'b00}));
			repeat (seed[12:8]) @(posedge sys_clk_in);
			irq_pending_in <= 1'b1;
			@(posedge sys_clk_in);
			irq_pending_in <= 1'b0;
			#1 chk(16'({power_mode_out, cpu_clk_en_out}), 16'h1);
		end
		enter(1'b0, 8'h01);
		wait_mode(2'h1);
		watchdog_expired_in <= 1'b1;
		@(posedge sys_clk_in);
		watchdog_expired_in <= 1'b0;
		wait_rst(10);
		repeat (8) @(posedge sys_clk_in);
		enter(1'b0, 8'h02);
		wait_mode(2'h2);
		{irq_pending_in, watchdog_expired_in} <= 2'b11;
		repeat (20) @(posedge sys_clk_in);
		{irq_pending_in, watchdog_expired_in} <= 2'b00;
		#1 chk(16'({power_mode_out, irq_timer_en_out}), 16'h4);
		ext_reset_n_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		ext_reset_n_in <= 1'b1;
		wait_rst(10);
		repeat (8) @(posedge sys_clk_in);
		clk_watch_en_in <= 1'b1;
		enter(1'b0, 8'h02);
		wait_mode(2'h2);
		wait_rst(6000);
		chk(16'(i > 4985 && i < 5010), 16'h1);
		clk_watch_en_in <= 1'b0;
		for (int w = 0; w < 2; w++) begin
			repeat (8) @(posedge sys_clk_in);
			enter(1'b1, 8'h20);
			wait_mode(2'h3);
			seed = lfsr(seed);
			repeat (seed[4:0]) @(posedge sys_clk_in);
			{port_match_in, comparator_low_in} <= w ? 2'b01 : 2'b10;
			// Wake pulse stands one cycle: look at it mid-cycle
			for (i = 0; i < 10 && wake_irq_out !== 1'b1; i++)
				@(negedge sys_clk_in);
			chk(16'({wake_irq_out, power_mode_out}), 16'h4);
			chk(16'(osc_control_rdata_out), 16'h0);
			@(posedge sys_clk_in);
			{port_match_in, comparator_low_in} <= 2'b00;
		end
		repeat (8) @(posedge sys_clk_in);
		summarize();
	end
endmodule : power_mode_controller_bench
bind power_mode_controller power_mode_controller_assertions CHK (
	.sys_clk_in, .reset_n_in, .ext_reset_n_in, .instr_done_in,
	.irq_pending_in, .clk_watch_en_in, .power_control_rdata_out,
	.cpu_clk_en_out, .periph_clk_en_out, .int_osc_en_out,
	.irq_timer_en_out, .sys_reset_n_out, .reset_vector_out,
	.power_mode_out, .wake_irq_out);
